// ===== hw/clid_defs.svh
// constants of the character lcd instruction decoder
// assumes a 200 MHz core clock and byte addressed wishbone words
`ifndef CLID_DEFS_SVH
`define CLID_DEFS_SVH

// clock period and execution times in ns
`define CLID_CLK_NS       5
`define CLID_T_SHORT_NS   18500
`define CLID_T_LONG_NS    760000
// least time in whole cycles, rounded up
`define CLID_CYC(ns)      ((((ns) + `CLID_CLK_NS - 1) / `CLID_CLK_NS))
`define CLID_SHORT_CYC    18'(`CLID_CYC(`CLID_T_SHORT_NS))

// register byte offsets
`define CLID_OFF_INSTR    8'h00
`define CLID_OFF_DATA     8'h04
`define CLID_OFF_STATUS   8'h08
`define CLID_OFF_CONFIG   8'h0c
`define CLID_OFF_GSEL     8'h10
`define CLID_OFF_GPIX     8'h14

// field positions
`define CLID_BUSY_BIT     7
`define CLID_GSEL_ROW_LSB 8

// reset values
`define CLID_RST_INC      1'b1
`define CLID_RST_BUS8     1'b1

// codes and address ranges
`define CLID_SPACE        8'h20
`define CLID_ONE_END      7'h4f
`define CLID_L1_END       7'h27
`define CLID_L2_BEG       7'h40
`define CLID_L2_END       7'h67
`define CLID_LEN_ONE      7'd80
`define CLID_LEN_TWO      7'd40
`define CLID_ROW_BOTTOM   3'h7

`endif

// ===== hw/clid_pkg.sv
// types of the character lcd instruction decoder
// assumes clid_defs.svh supplies all numeric constants
package clid_pkg;

	// execution state, one-hot
	typedef enum logic [2:0] {
		CLID_IDLE  = 3'b001,
		CLID_EXEC  = 3'b010,
		CLID_CLEAR = 3'b100
	} clid_state_e;

	// whole state of the decoder
	typedef struct packed {
		clid_state_e state;     // execution state
		logic        busy;      // busy flag copy
		logic [17:0] cnt;       // cycles left busy
		logic [6:0]  clr_idx;   // clear fill pointer
		logic        ack;       // bus answer
		logic [15:0] dat;       // bus read data
		logic [6:0]  addr_cnt;  // address counter
		logic        to_font;   // memory window: user font ram
		logic        inc;       // step direction up
		logic        shift_en;  // shift display on write
		logic        disp_on;   // display on
		logic        cur_on;    // cursor shown
		logic        blink;     // cursor blink
		logic        bus8;      // bus width select
		logic        two_line;  // two line mode
		logic        tall;      // taller font
		logic [6:0]  dshift;    // display shift amount
		logic [6:0]  gsel_addr; // glyph probe position
		logic [2:0]  gsel_row;  // glyph probe row
		logic [5:0]  gpix;      // probe result
	} clid_st_s;

endpackage

// ===== hw/clid_font_map.sv
// character code to user font ram mapping and row pixel forming
// assumes the caller reads the font ram row at font_addr_o
`timescale 1ns/1ps
`default_nettype none
`include "clid_defs.svh"

module clid_font_map (
	input  wire logic [7:0] code_i,        // display character code
	input  wire logic [2:0] row_i,         // glyph row
	input  wire logic [7:0] row_data_i,    // font ram row byte
	input  wire logic       cursor_here_i, // cursor shown here
	output logic            user_o,        // glyph from font ram
	output logic [5:0]      font_addr_o,   // font ram address
	output logic [4:0]      pix_o          // row pixels, bit 4 left
);
	// bottom row of the cursor cell
	logic cur_row;

	// R01 user glyph select
	assign user_o = (code_i[7:4] == 4'h0);
	// R02 R03 glyph and row address, code bit 3 ignored
	assign font_addr_o = {code_i[2:0], row_i};
	assign cur_row = cursor_here_i && (row_i == `CLID_ROW_BOTTOM);

	// pixel row forming
	always_comb begin
		// R06 R07 low five bits, one lights
		pix_o = user_o ? row_data_i[4:0] : 5'h00;
		// R04 cursor or-ed into bottom row
		if (cur_row) begin
			pix_o = 5'h1f;
		end
	end
endmodule
`default_nettype wire

// ===== hw/clid_top.sv
// character lcd instruction decoder with display and user font ram
// assumes a classic wishbone master on the same clock as CORE_CLK_I
//
// Contract
// R01 - upper nibble zero uses font ram
// R02 - code bits 2:0 pick glyph
// R03 - font address low bits are row
// R04 - cursor ORed into bottom glyph row
// R05 - host keeps glyph bottom rows zero
// R06 - pixels from data bits 4:0
// R07 - one lights pixel, zero dark
// R08 - data write or read, busy 18.5us
// R09 - clear fills spaces, zeroes counter
// R10 - clear forces increment, cursor home
// R11 - home zeroes counter and shift
// R12 - entry mode latches direction, shift
// R13 - display control latches three flags
// R14 - shift cursor or display, direction
// R15 - function set latches width, lines, font
// R16 - font address set, window font
// R17 - display address set, window display
// R18 - status returns busy and counter
// R19 - no instruction taken while busy
// R20 - counter steps after each access
// R21 - decode by highest set bit
// R22 - display address ranges per mode
//
// The register offsets and register access over Wishbone were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "clid_defs.svh"

module clid_top #(
	parameter logic [17:0] LONG_CYC = 18'(`CLID_CYC(`CLID_T_LONG_NS)) // clear, home
) (
	input  wire logic        CORE_CLK_I,  // core clock
	input  wire logic        RST_B_I,     // async reset, low
	input  wire logic        WB_CYC_I,    // bus cycle
	input  wire logic        WB_STB_I,    // bus strobe
	input  wire logic        WB_WE_I,     // write enable
	input  wire logic [7:0]  WB_ADR_I,    // byte address
	input  wire logic [31:0] WB_DAT_I,    // write data
	input  wire logic [3:0]  WB_SEL_I,    // byte lanes
	output logic      [31:0] WB_DAT_O,    // read data
	output logic             WB_ACK_O,    // answer
	output logic             BUSY_O,      // busy flag
	output logic             DISP_ON_O,   // display on
	output logic             CURSOR_ON_O, // cursor shown
	output logic             BLINK_O,     // cursor blink
	output logic             BUS8_O,      // eight bit bus
	output logic             TWO_LINE_O,  // two line mode
	output logic             TALL_FONT_O, // tall font
	output logic      [6:0]  SHIFT_O      // display shift
);
	import clid_pkg::*;

	clid_st_s    st_ff;             // registered state
	clid_st_s    nxt_st;            // next state
	logic [7:0]  disp_ram [0:127];  // display_data_ram
	logic [7:0]  fram [0:63];       // user_font_ram
	logic        dd_we;             // display ram write
	logic [6:0]  dd_wa;             // display ram address
	logic [7:0]  dd_wd;             // display ram data
	logic        fr_we;             // font ram write
	logic [5:0]  fr_wa;             // font ram address
	logic [7:0]  fr_wd;             // font ram data
	logic        req;               // new bus request
	logic        idle;              // ready for work
	logic [7:0]  ibyte;             // instruction byte
	logic [7:0]  ram_q;             // ram data at counter
	logic [7:0]  probe_code;        // probed character code
	logic [5:0]  probe_faddr;       // probed font address
	logic        probe_user;        // probed glyph is user
	logic [4:0]  probe_pix;         // probed pixels
	logic        probe_cur;         // cursor at probe

	// address counter step with line wrap
	function automatic logic [6:0] pos_step(input logic [6:0] pos, input logic up,
	                                        input logic font, input logic two);
		logic [6:0] r;
		r = up ? 7'(pos + 7'd1) : 7'(pos - 7'd1);
		// R22 wrap at the line ends of each mode
		if (font) begin
			r[6] = 1'b0;
		end else if (two) begin
			if (up && pos == `CLID_L1_END) begin
				r = `CLID_L2_BEG;
			end else if (up && pos == `CLID_L2_END) begin
				r = 7'h00;
			end else if (!up && pos == 7'h00) begin
				r = `CLID_L2_END;
			end else if (!up && pos == `CLID_L2_BEG) begin
				r = `CLID_L1_END;
			end
		end else begin
			if (up && pos == `CLID_ONE_END) begin
				r = 7'h00;
			end else if (!up && pos == 7'h00) begin
				r = `CLID_ONE_END;
			end
		end
		return r;
	endfunction

	// display shift step, wraps at line length
	function automatic logic [6:0] sh_step(input logic [6:0] sh, input logic left,
	                                       input logic two);
		logic [6:0] len;
		logic [6:0] r;
		len = two ? `CLID_LEN_TWO : `CLID_LEN_ONE;
		if (left) begin
			r = (sh >= 7'(len - 7'd1)) ? 7'h00 : 7'(sh + 7'd1);
		end else begin
			r = (sh == 7'h00) ? 7'(len - 7'd1) : 7'(sh - 7'd1);
		end
		return r;
	endfunction

	// position of the highest set bit, 8 when none
	function automatic logic [3:0] top_bit(input logic [7:0] b);
		logic [3:0] r;
		r = 4'd8;
		for (int i = 0; i < 8; i++) begin
			if (b[i]) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction

	assign req   = WB_CYC_I && WB_STB_I && !st_ff.ack;
	assign idle  = (st_ff.state == CLID_IDLE);
	assign ibyte = WB_DAT_I[7:0];
	assign ram_q = st_ff.to_font ? fram[st_ff.addr_cnt[5:0]] : disp_ram[st_ff.addr_cnt];

	// glyph probe: character at a display position, row pixels
	assign probe_code = disp_ram[st_ff.gsel_addr];
	assign probe_cur  = st_ff.cur_on && !st_ff.to_font && (st_ff.gsel_addr == st_ff.addr_cnt);

	clid_font_map u_map (
		.code_i        (probe_code),
		.row_i         (st_ff.gsel_row),
		.row_data_i    (fram[probe_faddr]),
		.cursor_here_i (probe_cur),
		.user_o        (probe_user),
		.font_addr_o   (probe_faddr),
		.pix_o         (probe_pix)
	);

	// next state: bus decode, instruction execution, busy timing
	always_comb begin
		nxt_st = st_ff;
		nxt_st.ack = 1'b0;
		nxt_st.gpix = {probe_user, probe_pix};
		dd_we = 1'b0;
		dd_wa = st_ff.addr_cnt;
		dd_wd = ibyte;
		fr_we = 1'b0;
		fr_wa = st_ff.addr_cnt[5:0];
		fr_wd = ibyte;

		// busy countdown and clear fill
		unique case (st_ff.state)
			CLID_IDLE: begin
				nxt_st.cnt = 18'h0;
			end
			CLID_EXEC: begin
				nxt_st.cnt = 18'(st_ff.cnt - 18'd1);
				if (st_ff.cnt <= 18'd1) begin
					nxt_st.state = CLID_IDLE;
				end
			end
			CLID_CLEAR: begin
				// R09 space into every location
				dd_we = 1'b1;
				dd_wa = st_ff.clr_idx;
				dd_wd = `CLID_SPACE;
				nxt_st.clr_idx = 7'(st_ff.clr_idx + 7'd1);
				nxt_st.cnt = 18'(st_ff.cnt - 18'd1);
				if (st_ff.cnt <= 18'd1) begin
					nxt_st.state = CLID_IDLE;
				end
			end
		endcase

		// bus access, answered one cycle later
		if (req) begin
			nxt_st.ack = 1'b1;
			nxt_st.dat = 16'h0000;
			case (WB_ADR_I)
				`CLID_OFF_INSTR: begin
					// R19 R21 taken only when idle, by top bit
					if (WB_WE_I && WB_SEL_I[0] && idle) begin
						case (top_bit(ibyte))
							4'd7: begin
								// R17 display address set
								nxt_st.addr_cnt = ibyte[6:0];
								nxt_st.to_font = 1'b0;
							end
							4'd6: begin
								// R16 font address set
								nxt_st.addr_cnt = {1'b0, ibyte[5:0]};
								nxt_st.to_font = 1'b1;
							end
							4'd5: begin
								// R15 function set
								nxt_st.bus8 = ibyte[4];
								nxt_st.two_line = ibyte[3];
								nxt_st.tall = ibyte[2];
							end
							4'd4: begin
								// R14 display or cursor shift
								if (ibyte[3]) begin
									nxt_st.dshift = sh_step(st_ff.dshift, !ibyte[2],
									                        st_ff.two_line);
								end else begin
									nxt_st.addr_cnt = pos_step(st_ff.addr_cnt, ibyte[2],
									                           st_ff.to_font, st_ff.two_line);
								end
							end
							4'd3: begin
								// R13 display control
								nxt_st.disp_on = ibyte[2];
								nxt_st.cur_on = ibyte[1];
								nxt_st.blink = ibyte[0];
							end
							4'd2: begin
								// R12 entry mode
								nxt_st.inc = ibyte[1];
								nxt_st.shift_en = ibyte[0];
							end
							4'd1: begin
								// R11 return home
								nxt_st.addr_cnt = 7'h00;
								nxt_st.dshift = 7'h00;
								nxt_st.to_font = 1'b0;
							end
							4'd0: begin
								// R09 R10 clear, increment, cursor home
								nxt_st.addr_cnt = 7'h00;
								nxt_st.dshift = 7'h00;
								nxt_st.to_font = 1'b0;
								nxt_st.inc = 1'b1;
								nxt_st.clr_idx = 7'h00;
							end
							default: begin
								// zero byte does nothing
							end
						endcase
						// execution time per instruction
						if (top_bit(ibyte) == 4'd0) begin
							nxt_st.state = CLID_CLEAR;
							nxt_st.cnt = LONG_CYC;
						end else if (top_bit(ibyte) == 4'd1) begin
							nxt_st.state = CLID_EXEC;
							nxt_st.cnt = LONG_CYC;
						end else if (top_bit(ibyte) != 4'd8) begin
							nxt_st.state = CLID_EXEC;
							nxt_st.cnt = `CLID_SHORT_CYC;
						end
					end
				end
				`CLID_OFF_DATA: begin
					// R08 data access, refused while busy
					if (idle && (!WB_WE_I || WB_SEL_I[0])) begin
						if (WB_WE_I) begin
							dd_we = !st_ff.to_font;
							fr_we = st_ff.to_font;
							if (st_ff.shift_en && !st_ff.to_font) begin
								nxt_st.dshift = sh_step(st_ff.dshift, st_ff.inc,
								                        st_ff.two_line);
							end
						end else begin
							nxt_st.dat = {8'h00, ram_q};
						end
						// R20 counter steps after access
						nxt_st.addr_cnt = pos_step(st_ff.addr_cnt, st_ff.inc, st_ff.to_font,
						                           st_ff.two_line);
						nxt_st.state = CLID_EXEC;
						nxt_st.cnt = `CLID_SHORT_CYC;
					end
				end
				`CLID_OFF_STATUS: begin
					// R18 busy and counter, no delay
					nxt_st.dat = {8'h00, st_ff.busy, st_ff.addr_cnt};
				end
				`CLID_OFF_CONFIG: begin
					// mode flags readback
					nxt_st.dat = {7'h00, st_ff.to_font, st_ff.bus8, st_ff.two_line,
					              st_ff.tall, st_ff.disp_on, st_ff.cur_on,
					              st_ff.blink, st_ff.inc, st_ff.shift_en};
				end
				`CLID_OFF_GSEL: begin
					// glyph probe select
					if (WB_WE_I && WB_SEL_I[1:0] == 2'b11) begin
						nxt_st.gsel_addr = WB_DAT_I[6:0];
						nxt_st.gsel_row = WB_DAT_I[`CLID_GSEL_ROW_LSB +: 3];
					end
					nxt_st.dat = {5'h00, st_ff.gsel_row, 1'b0, st_ff.gsel_addr};
				end
				`CLID_OFF_GPIX: begin
					// R01 R04 probe result: user flag, pixels
					nxt_st.dat = {10'h000, st_ff.gpix};
				end
				default: begin
					// unmapped: answer zero, no effect
				end
			endcase
		end
		nxt_st.busy = (nxt_st.state != CLID_IDLE);
	end

	// state register
	always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			st_ff <= '0;
			st_ff.state <= CLID_IDLE;
			st_ff.inc <= `CLID_RST_INC;
			st_ff.bus8 <= `CLID_RST_BUS8;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// display ram write port
	always_ff @(posedge CORE_CLK_I) begin
		if (dd_we) begin
			disp_ram[dd_wa] <= dd_wd;
		end
	end

	// font ram write port
	always_ff @(posedge CORE_CLK_I) begin
		if (fr_we) begin
			fram[fr_wa] <= fr_wd;
		end
	end

	// outputs straight from state flops
	assign WB_DAT_O    = {16'h0000, st_ff.dat};
	assign WB_ACK_O    = st_ff.ack;
	assign BUSY_O      = st_ff.busy;
	assign DISP_ON_O   = st_ff.disp_on;
	assign CURSOR_ON_O = st_ff.cur_on;
	assign BLINK_O     = st_ff.blink;
	assign BUS8_O      = st_ff.bus8;
	assign TWO_LINE_O  = st_ff.two_line;
	assign TALL_FONT_O = st_ff.tall;
	assign SHIFT_O     = st_ff.dshift;
endmodule
`default_nettype wire

// ===== bench/clid_host_model.sv
// host side model: classic wishbone master polling the busy flag
// assumes the decoder answers every request with a one cycle ack
`timescale 1ns/1ps
`default_nettype none
module clid_host_model (
	input  wire logic        clk_i, // core clock
	input  wire logic        ack_i, // answer
	input  wire logic [31:0] dat_i, // read data
	output logic             cyc_o, // bus cycle
	output logic             stb_o, // strobe
	output logic             we_o,  // write enable
	output logic      [7:0]  adr_o, // byte address
	output logic      [31:0] dat_o, // write data
	output logic      [3:0]  sel_o  // byte lanes
);
	logic tmo = 1'b0; // set when a wait ran out
	// idle bus from time zero
	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o  = 1'b0;
		adr_o = 8'h00;
		dat_o = 32'h0;
		sel_o = 4'h0;
	end
	// one classic cycle, request held until ack is sampled
	task automatic acc(input logic we, input logic [7:0] a, input logic [15:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o  <= we;
		adr_o <= a;
		dat_o <= {16'h0, d};
		sel_o <= 4'h3;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_i !== 1'b1 && n < 16);
		q = dat_i;
		if (n >= 16) begin
			tmo = 1'b1;
		end
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
	endtask
	task automatic poll();
		logic [31:0] q;
		int n;
		n = 0;
		q = 32'h80;
		while (q[7] !== 1'b0 && n < 3000) begin
			acc(1'b0, 8'h08, 16'h0, q);
			n++;
		end
		if (n >= 3000) begin
			tmo = 1'b1;
		end
	endtask
	task automatic cmd(input logic [7:0] c);
		logic [31:0] q;
		poll();
		acc(1'b1, 8'h00, {8'h0, c}, q);
	endtask
endmodule
`default_nettype wire

// ===== bench/clid_top_assertions.sv
// concurrent checks on the decoder top ports
// assumes it is bound onto clid_top, single clock domain
`timescale 1ns/1ps
`default_nettype none
module clid_assertions #(
	parameter logic [17:0] LONG_CYC = 18'd200 // clear and home busy length
) (
	input wire logic        CORE_CLK_I,  // core clock
	input wire logic        RST_B_I,     // reset, low
	input wire logic        WB_CYC_I,    // bus cycle
	input wire logic        WB_STB_I,    // strobe
	input wire logic        WB_WE_I,     // write enable
	input wire logic [7:0]  WB_ADR_I,    // byte address
	input wire logic [31:0] WB_DAT_I,    // write data
	input wire logic [3:0]  WB_SEL_I,    // byte lanes
	input wire logic [31:0] WB_DAT_O,    // read data
	input wire logic        WB_ACK_O,    // answer
	input wire logic        BUSY_O,      // busy flag
	input wire logic        DISP_ON_O,   // display on
	input wire logic        CURSOR_ON_O, // cursor shown
	input wire logic        BLINK_O,     // blink
	input wire logic        BUS8_O,      // bus width
	input wire logic        TWO_LINE_O,  // two lines
	input wire logic        TALL_FONT_O, // tall font
	input wire logic [6:0]  SHIFT_O      // display shift
);
	logic        take;   // request taken at this edge
	logic        iw;     // instruction accepted
	logic [17:0] run_ff; // cycles busy so far
	assign take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	assign iw = take && WB_WE_I && WB_ADR_I == 8'h00 && WB_SEL_I[0] && !BUSY_O;
	// busy run length, cleared while idle
	always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			run_ff <= 18'h0;
		end else begin
			run_ff <= BUSY_O ? run_ff + 18'h1 : 18'h0;
		end
	end
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (!RST_B_I);
	a_ack_pulse: assert property (take |=> WB_ACK_O ##1 !WB_ACK_O)
		else $error("ack is not a single pulse after a request");
	a_status_busy: assert property (take && !WB_WE_I && WB_ADR_I == 8'h08 |=> WB_DAT_O[7] == $past(BUSY_O))
		else $error("status busy bit differs from busy flag");
	a_data_busy: assert property (take && WB_ADR_I == 8'h04 && !BUSY_O |=> BUSY_O)
		else $error("data access did not start busy");
	a_busy_len: assert property ($fell(BUSY_O) |-> run_ff == 18'd3700 || run_ff == LONG_CYC)
		else $error("busy length wrong");
	a_drop_busy: assert property (take && WB_WE_I && WB_ADR_I == 8'h00 && BUSY_O |=> $stable({DISP_ON_O, CURSOR_ON_O, BLINK_O, BUS8_O, TWO_LINE_O, TALL_FONT_O, SHIFT_O}))
		else $error("instruction taken while busy");
	a_disp_ctrl: assert property (iw && WB_DAT_I[7:3] == 5'b00001 |=> {DISP_ON_O, CURSOR_ON_O, BLINK_O} == $past(WB_DAT_I[2:0]))
		else $error("display control flags wrong");
	a_func_set: assert property (iw && WB_DAT_I[7:5] == 3'b001 |=> {BUS8_O, TWO_LINE_O, TALL_FONT_O} == $past(WB_DAT_I[4:2]))
		else $error("function set flags wrong");
	a_home_long: assert property (iw && WB_DAT_I[7:1] == 7'h01 |=> SHIFT_O == 7'h0 && BUSY_O [*8])
		else $error("home did not clear shift or hold busy");
	a_clear_shift: assert property (iw && WB_DAT_I[7:0] == 8'h01 |=> SHIFT_O == 7'h0 && BUSY_O)
		else $error("clear did not reset shift");
	a_shift_disp: assert property (iw && WB_DAT_I[7:3] == 5'b00011 |=> SHIFT_O != $past(SHIFT_O))
		else $error("display shift did not move");
	c_clear: cover property (iw && WB_DAT_I[7:0] == 8'h01);
	c_busy_end: cover property ($fell(BUSY_O));
	c_probe: cover property (take && WB_ADR_I == 8'h14);
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// self-checking bench of the lcd instruction decoder
// assumes clid_host_model drives every bus input of the design
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [17:0] LONG_CYC = 18'd200; // short clear and home
	logic        clk, rst_b, cyc, stb, we, ack, busy;  // clock, reset, bus
	logic        disp, cur, blink, bus8, two, tall;     // mode flags
	logic [7:0]  adr;                                   // byte address
	logic [3:0]  sel;                                   // byte lanes
	logic [31:0] wdat, rdat, q;                         // bus data, last read
	logic [6:0]  shift;                                 // display shift
	int          failures = 0;                          // mismatches
	int          samples_checked = 0;                   // comparisons
	always #2.5 clk = ~clk;
	clid_top #(.LONG_CYC(LONG_CYC)) clid_top_inst (.CORE_CLK_I(clk), .RST_B_I(rst_b),
		.WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_DAT_I(wdat),
		.WB_SEL_I(sel), .WB_DAT_O(rdat), .WB_ACK_O(ack), .BUSY_O(busy), .DISP_ON_O(disp),
		.CURSOR_ON_O(cur), .BLINK_O(blink), .BUS8_O(bus8), .TWO_LINE_O(two),
		.TALL_FONT_O(tall), .SHIFT_O(shift));
	clid_host_model clid_host_model_inst (.clk_i(clk), .ack_i(ack), .dat_i(rdat),
		.cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .dat_o(wdat), .sel_o(sel));
	// verdict and end of run
	task automatic end_of_test();
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// compare, a host timeout also fails and ends the run
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp || clid_host_model_inst.tmo) begin
			failures++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
		if (clid_host_model_inst.tmo) begin
			end_of_test();
		end
	endtask
	task automatic cmd(input logic [7:0] c);
		clid_host_model_inst.cmd(c);
	endtask
	task automatic rd(input logic [7:0] a);
		clid_host_model_inst.acc(1'b0, a, 16'h0, q);
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		clid_host_model_inst.acc(1'b1, a, d, q);
	endtask
	task automatic dwr(input logic [7:0] d);
		clid_host_model_inst.poll();
		wr(8'h04, {8'h0, d});
	endtask
	// reset state and an unmapped place
	task automatic s_reset();
		rd(8'h0c);
		chk("config", q, 32'h82);
		rd(8'h1c);
		chk("unmapped", q, 32'h0);
	endtask
	// display control, function set, entry mode
	task automatic s_modes();
		cmd(8'h0d);
		chk("dcb", 32'({disp, cur, blink}), 32'h5);
		cmd(8'h0a);
		chk("dcb", 32'({disp, cur, blink}), 32'h2);
		cmd(8'h34);
		chk("func", 32'({bus8, two, tall}), 32'h5);
		cmd(8'h38);
		chk("func", 32'({bus8, two, tall}), 32'h6);
		cmd(8'h04);
		rd(8'h0c);
		chk("entry", 32'(q[1:0]), 32'h0);
	endtask
	// clear fills spaces and forces increment
	task automatic s_clear();
		cmd(8'h01);
		rd(8'h08);
		chk("clr status", q, 32'h80);
		rd(8'h0c);
		chk("clr inc", 32'(q[1]), 32'h1);
		cmd(8'h80);
		clid_host_model_inst.poll();
		rd(8'h04);
		chk("space", q, 32'h20);
		rd(8'h08);
		chk("step", 32'(q[6:0]), 32'h1);
	endtask
	// user glyph mapping and cursor row
	task automatic s_font();
		cmd(8'h4a);
		dwr(8'he5);
		cmd(8'h4f);
		dwr(8'h00);
		cmd(8'h80);
		dwr(8'h09);
		wr(8'h10, 16'h0200);
		repeat (4) @(posedge clk);
		rd(8'h14);
		chk("row2", q, 32'h25);
		wr(8'h10, 16'h0700);
		repeat (4) @(posedge clk);
		rd(8'h14);
		chk("row7", q, 32'h20);
		wr(8'h10, 16'h0701);
		repeat (4) @(posedge clk);
		rd(8'h14);
		chk("cursor", q, 32'h1f);
	endtask
	// two-line wrap of the counter
	task automatic s_lines();
		cmd(8'ha7);
		dwr(8'h41);
		rd(8'h08);
		chk("wrap", 32'(q[6:0]), 32'h40);
	endtask
	// requests while busy are dropped
	task automatic s_busy();
		clid_host_model_inst.poll();
		wr(8'h00, 16'h000f);
		wr(8'h00, 16'h0008);
		rd(8'h04);
		chk("busy read", q, 32'h0);
		rd(8'h08);
		chk("busy status", q, 32'hc0);
		chk("disp kept", 32'(disp), 32'h1);
	endtask
	// display and cursor shift, then home
	task automatic s_shift();
		cmd(8'h18);
		chk("left", 32'(shift), 32'h1);
		cmd(8'h1c);
		chk("right", 32'(shift), 32'h0);
		cmd(8'h1c);
		chk("wrap", 32'(shift), 32'd39);
		cmd(8'h14);
		rd(8'h08);
		chk("cur right", 32'(q[6:0]), 32'h41);
		cmd(8'h02);
		rd(8'h08);
		chk("home", q, 32'h80);
		chk("home shift", 32'(shift), 32'h0);
	endtask
	// shift on write follows the entry direction
	task automatic s_entry();
		cmd(8'h07);
		dwr(8'h41);
		chk("wr shift left", 32'(shift), 32'h1);
		cmd(8'h05);
		dwr(8'h42);
		chk("wr shift right", 32'(shift), 32'h0);
		rd(8'h08);
		chk("dec step", 32'(q[6:0]), 32'h0);
	endtask
	// main sequence
	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		s_reset();
		s_modes();
		s_clear();
		s_font();
		s_lines();
		s_busy();
		s_shift();
		s_entry();
		end_of_test();
	end
endmodule
bind clid_top clid_assertions #(.LONG_CYC(LONG_CYC)) clid_assertions_inst (
	.CORE_CLK_I(CORE_CLK_I), .RST_B_I(RST_B_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
	.WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .WB_SEL_I(WB_SEL_I),
	.WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .BUSY_O(BUSY_O), .DISP_ON_O(DISP_ON_O),
	.CURSOR_ON_O(CURSOR_ON_O), .BLINK_O(BLINK_O), .BUS8_O(BUS8_O), .TWO_LINE_O(TWO_LINE_O),
	.TALL_FONT_O(TALL_FONT_O), .SHIFT_O(SHIFT_O));
`default_nettype wire
